// >>> design/pad_cell.sv
`timescale 1ns/1ps
module pad_cell
  import pport_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_n_i,
  // Decoded function
  input  wire pad_ctl_t ctl_i,
  // Pad drive
  output logic          pad_o,
  output logic          oe_o
);

  wire logic val_nxt;

  assign val_nxt = ctl_i.alt_sel ? ctl_i.alt_bit : ctl_i.addr_bit;

  // A disabled pad is released to general-purpose I/O
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_o <= 1'b0;
      oe_o <= 1'b0;
    end else begin
      pad_o <= ctl_i.en ? val_nxt : 1'b0;
      oe_o <= ctl_i.en;
    end
  end

endmodule

// >>> design/pport_map.svh
`ifndef PPORT_MAP_SVH
`define PPORT_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CTRL_OFS       8'h00
`define PAD_EN_OFS     8'h04
`define STATUS_OFS     8'h08
`define IRQ_STAT_OFS   8'h0c
`define IRQ_MASK_OFS   8'h10
`define ADDR_OFS       8'h14
`define IN_SLOT_OFS    8'h20
`define OUT_SLOT_OFS   8'h30

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_SLAVE_EN  0
`define CTRL_CS_FUNC_LSB 6
`define CTRL_MUX_LSB   11
`define ST_IN_ALL_FULL 15
`define ST_IN_OVF      14
`define ST_IN_SLOT_LSB 8
`define ST_OUT_ALL_EMPTY 7
`define ST_OUT_UNF     6
`define ST_OUT_SLOT_LSB 0
`define IRQ_OVF_BIT    0
`define IRQ_UNF_BIT    1

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define CS_FUNC_TWO_ONLY 2'h1
`define CS_FUNC_BOTH   2'h2
`define MUX_DEMUX      2'h0
`define CTRL_RST       32'h0000_0000
`define PAD_EN_RST     16'h0000
`define IN_FULL_RST    1'b0
`define OUT_EMPTY_RST  1'b1

`endif

// >>> design/pport_pkg.sv
package pport_pkg;

  // Pins of the external parallel master, as seen at the pads
  typedef struct packed {
    logic       cs;
    logic       wr;
    logic       rd;
    logic [7:0] data;
  } ext_bus_t;

  // Decoded pad function for one address pad
  typedef struct packed {
    logic en;
    logic alt_sel;
    logic addr_bit;
    logic alt_bit;
  } pad_ctl_t;

endpackage

// >>> design/pport_slave.sv
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "pport_map.svh"

// What this block does
// - Top pads enabled: address or chip selects
// - Middle enable bits route address lines to pads
// - Low pads enabled: address or latch strobes
// - Chip-select field picks top pad function
// - Address mux mode picks low pad function
// - Pad enable upper half unimplemented
// - Status tracks slave buffers in slave mode
// - Input-all-full while every input slot full
// - Input overflow sticky, cleared by software write
// - Slot full flags clear on software read
// - Output-all-empty while every output slot empty
// - Output underflow sticky, cleared by software write
// - Slot empty flags clear on software write
// - Overflow or underflow raises error interrupt
// - Unused status bits read zero
module pport_slave
  import pport_pkg::*;
#(
  parameter int SLOTS = 4,
  parameter int PADS = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // APB slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic [31:0]           prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // External parallel master
  input  wire ext_bus_t         ext_i,
  output logic [7:0]            ext_data_o,
  output logic                  ext_data_oe_o,
  // Latch strobes from the port sequencer
  input  wire logic             latch_high_i,
  input  wire logic             latch_low_i,
  // Address pads
  output logic [PADS-1:0]       pad_out_o,
  output logic [PADS-1:0]       pad_oe_o,
  // Interrupt
  output logic                  port_error_interrupt_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ext_bus_t ext_s1_r;
  ext_bus_t ext_s2_r;
  ext_bus_t ext_prev_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_s1_r <= '0;
      ext_s2_r <= '0;
      ext_prev_r <= '0;
    end else begin
      ext_s1_r <= ext_i;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [15:0] pad_en_r;
  logic [15:0] addr_r;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_stat_r;
  logic in_ovf_r;
  logic out_unf_r;
  logic [1:0] in_wp_r;
  logic [1:0] out_rp_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic access;
  wire logic wr_fire;
  wire logic rd_fire;
  wire logic sel_ctrl;
  wire logic sel_pad_en;
  wire logic sel_status;
  wire logic sel_irq_stat;
  wire logic sel_irq_mask;
  wire logic sel_addr;
  wire logic sel_in;
  wire logic sel_out;
  wire logic mapped;
  wire logic [1:0] slot_idx;

  // One wait state lets read data come straight from a flip-flop
  assign access = psel_i & penable_i;
  assign wr_fire = access & pready_o & pwrite_i;
  assign rd_fire = access & pready_o & ~pwrite_i;
  assign sel_ctrl = paddr_i == `CTRL_OFS;
  assign sel_pad_en = paddr_i == `PAD_EN_OFS;
  assign sel_status = paddr_i == `STATUS_OFS;
  assign sel_irq_stat = paddr_i == `IRQ_STAT_OFS;
  assign sel_irq_mask = paddr_i == `IRQ_MASK_OFS;
  assign sel_addr = paddr_i == `ADDR_OFS;
  assign sel_in = (paddr_i & 8'hf3) == `IN_SLOT_OFS;
  assign sel_out = (paddr_i & 8'hf3) == `OUT_SLOT_OFS;
  assign slot_idx = paddr_i[3:2];
  assign mapped = sel_ctrl | sel_pad_en | sel_status | sel_irq_stat |
                  sel_irq_mask | sel_addr | sel_in | sel_out;

  // ----------------------------------------------------------------
  // Slave strobes from the external master
  // ----------------------------------------------------------------
  wire logic slave_en;
  wire logic ext_wr_pulse;
  wire logic ext_rd_pulse;
  wire logic [SLOTS-1:0] in_full;
  wire logic [SLOTS-1:0] out_empty;
  wire logic [7:0] in_data [SLOTS];
  wire logic [7:0] out_data [SLOTS];
  wire logic ovf_evt;
  wire logic unf_evt;
  wire logic in_all_full;
  wire logic out_all_empty;

  // Strobes are ignored outside slave mode
  assign slave_en = ctrl_r[`CTRL_SLAVE_EN];
  assign ext_wr_pulse = slave_en & ext_s2_r.cs & ext_s2_r.wr &
                        ~ext_prev_r.wr;
  assign ext_rd_pulse = slave_en & ext_s2_r.cs & ext_s2_r.rd &
                        ~ext_prev_r.rd;
  assign ovf_evt = ext_wr_pulse & in_full[in_wp_r];
  assign unf_evt = ext_rd_pulse & out_empty[out_rp_r];
  assign in_all_full = &in_full;
  assign out_all_empty = &out_empty;

  // ----------------------------------------------------------------
  // Buffer slots
  // ----------------------------------------------------------------
  for (genvar i = 0; i < SLOTS; i++) begin : g_slot
    wire logic in_set;
    wire logic in_clr;
    wire logic out_set;
    wire logic out_clr;

    // A write to a full slot is dropped and only flags overflow
    assign in_set = ext_wr_pulse & (in_wp_r == 2'(i)) & ~in_full[i];
    assign in_clr = rd_fire & sel_in & (slot_idx == 2'(i));
    assign out_set = ext_rd_pulse & (out_rp_r == 2'(i)) & ~out_empty[i];
    assign out_clr = wr_fire & sel_out & (slot_idx == 2'(i));

    slot_buf #(.W(8), .FLAG_RST(`IN_FULL_RST)) u_in (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .set_i(in_set),
      .clr_i(in_clr),
      .load_i(in_set),
      .data_i(ext_s2_r.data),
      .flag_o(in_full[i]),
      .data_o(in_data[i])
    );

    slot_buf #(.W(8), .FLAG_RST(`OUT_EMPTY_RST)) u_out (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .set_i(out_set),
      .clr_i(out_clr),
      .load_i(out_clr),
      .data_i(pwdata_i[7:0]),
      .flag_o(out_empty[i]),
      .data_o(out_data[i])
    );
  end

  // Slots are taken in turn; a refused access does not advance
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_wp_r <= 2'h0;
      out_rp_r <= 2'h0;
    end else begin
      if (ext_wr_pulse & ~in_full[in_wp_r]) begin
        in_wp_r <= in_wp_r + 2'h1;
      end
      if (ext_rd_pulse & ~out_empty[out_rp_r]) begin
        out_rp_r <= out_rp_r + 2'h1;
      end
    end
  end

  // An empty slot answers zero to the external master
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_data_o <= 8'h00;
      ext_data_oe_o <= 1'b0;
    end else begin
      if (ext_rd_pulse) begin
        ext_data_o <= out_empty[out_rp_r] ? 8'h00 : out_data[out_rp_r];
      end
      ext_data_oe_o <= slave_en & ext_s2_r.cs & ext_s2_r.rd;
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------
  wire logic [31:0] status_val;
  wire logic in_ovf_clr;
  wire logic out_unf_clr;
  wire logic [1:0] irq_evt;
  wire logic [1:0] irq_rd_clr;

  assign status_val = {16'h0000, in_all_full, in_ovf_r, 2'h0, in_full,
                       out_all_empty, out_unf_r, 2'h0, out_empty};
  // Writing zero clears a sticky flag; writing one leaves it
  assign in_ovf_clr = wr_fire & sel_status & ~pwdata_i[`ST_IN_OVF];
  assign out_unf_clr = wr_fire & sel_status & ~pwdata_i[`ST_OUT_UNF];
  assign irq_evt = {unf_evt, ovf_evt};
  // Only bits already shown to software are cleared by the read
  assign irq_rd_clr = (rd_fire & sel_irq_stat) ? prdata_o[1:0] : 2'h0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_ovf_r <= 1'b0;
      out_unf_r <= 1'b0;
    end else begin
      in_ovf_r <= ovf_evt | (in_ovf_r & ~in_ovf_clr);
      out_unf_r <= unf_evt | (out_unf_r & ~out_unf_clr);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_r <= 2'h0;
      port_error_interrupt_o <= 1'b0;
    end else begin
      irq_stat_r <= irq_evt | (irq_stat_r & ~irq_rd_clr);
      // A set mask bit blocks its source; all sources pass after reset
      port_error_interrupt_o <= |(irq_stat_r & ~irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `CTRL_RST;
      pad_en_r <= `PAD_EN_RST;
      addr_r <= 16'h0000;
      irq_mask_r <= 2'h0;
    end else if (wr_fire) begin
      if (sel_ctrl) begin
        ctrl_r <= pwdata_i;
      end
      if (sel_pad_en) begin
        pad_en_r <= pwdata_i[15:0];
      end
      if (sel_addr) begin
        addr_r <= pwdata_i[15:0];
      end
      if (sel_irq_mask) begin
        irq_mask_r <= pwdata_i[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB read and handshake
  // ----------------------------------------------------------------
  wire logic [31:0] rd_val;

  assign rd_val =
    sel_ctrl     ? ctrl_r :
    sel_pad_en   ? {16'h0000, pad_en_r} :
    sel_status   ? status_val :
    sel_irq_stat ? {30'h0, irq_stat_r} :
    sel_irq_mask ? {30'h0, irq_mask_r} :
    sel_addr     ? {16'h0000, addr_r} :
    sel_in       ? {24'h0, in_data[slot_idx]} :
    sel_out      ? {24'h0, out_data[slot_idx]} :
                   32'h0000_0000;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= access & ~pready_o;
      if (access & ~pready_o) begin
        prdata_o <= rd_val;
        pslverr_o <= ~mapped;
      end else begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pad functions
  // ----------------------------------------------------------------
  wire logic [1:0] cs_func;
  wire logic [1:0] mux_mode;
  wire logic [PADS-1:0] alt_sel;
  wire logic [PADS-1:0] alt_bit;

  assign cs_func = ctrl_r[`CTRL_CS_FUNC_LSB +: 2];
  assign mux_mode = ctrl_r[`CTRL_MUX_LSB +: 2];
  // Chip selects are active when their address register bit is set
  assign alt_sel[15] = (cs_func == `CS_FUNC_TWO_ONLY) |
                       (cs_func == `CS_FUNC_BOTH);
  assign alt_sel[14] = cs_func == `CS_FUNC_BOTH;
  assign alt_sel[13:2] = 12'h000;
  assign alt_sel[1] = mux_mode != `MUX_DEMUX;
  assign alt_sel[0] = mux_mode != `MUX_DEMUX;
  assign alt_bit = {addr_r[15:14], 12'h000, latch_high_i, latch_low_i};

  for (genvar p = 0; p < PADS; p++) begin : g_pad
    pad_ctl_t ctl;

    assign ctl = '{en: pad_en_r[p], alt_sel: alt_sel[p],
                   addr_bit: addr_r[p], alt_bit: alt_bit[p]};

    // Top pads middle pads low pads
    pad_cell u_pad (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ctl_i(ctl),
      .pad_o(pad_out_o[p]),
      .oe_o(pad_oe_o[p])
    );
  end

endmodule

// >>> design/slot_buf.sv
`timescale 1ns/1ps
module slot_buf #(
  parameter int W = 8,
  parameter logic FLAG_RST = 1'b0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Flag control
  input  wire logic         set_i,
  input  wire logic         clr_i,
  // Byte storage
  input  wire logic         load_i,
  input  wire logic [W-1:0] data_i,
  output logic              flag_o,
  output logic [W-1:0]      data_o
);

  // Set wins so an event in the clearing cycle is never lost
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= FLAG_RST;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= '0;
    end else if (load_i) begin
      data_o <= data_i;
    end
  end

endmodule

// >>> verification/ext_master_model.sv
`timescale 1ns/1ps
module ext_master_model
  import pport_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] data_i,
  output ext_bus_t bus_o
);
  initial bus_o = '0;
  // One strobe moves one byte; data settles two cycles before it
  task automatic strobe(input logic w, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_i);
    bus_o.cs <= 1'b1;
    bus_o.data <= d;
    repeat (2) @(posedge clk_i);
    bus_o.wr <= w;
    bus_o.rd <= !w;
    repeat (5) @(posedge clk_i);
    q = data_i;
    bus_o.wr <= 1'b0;
    bus_o.rd <= 1'b0;
    repeat (3) @(posedge clk_i);
    bus_o.cs <= 1'b0;
    // Released lines must not keep looking like the last byte
    bus_o.data <= ~d;
  endtask
endmodule

// >>> verification/pport_slave_props.sv
`timescale 1ns/1ps
`include "pport_map.svh"
module pport_slave_props
  import pport_pkg::*;
#(
  parameter int SLOTS = 4,
  parameter int PADS = 16
) (
  // Clock, reset and APB
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Parallel side, pads, interrupt
  input wire ext_bus_t ext_i,
  input wire logic [7:0] ext_data_o,
  input wire logic ext_data_oe_o,
  input wire logic latch_high_i,
  input wire logic latch_low_i,
  input wire logic [PADS-1:0] pad_out_o,
  input wire logic [PADS-1:0] pad_oe_o,
  input wire logic port_error_interrupt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire ack = psel_i && penable_i && pready_o;
  wire rd_ack = ack && !pwrite_i;
  wire wr_ack = ack && pwrite_i;
  wire st_rd = rd_ack && paddr_i == `STATUS_OFS;

  stat_zero_a: assert property (st_rd |-> prdata_o[31:16] == '0 &&
    prdata_o[13:12] == '0 && prdata_o[5:4] == '0)
    else $error("Unused status bits not zero");
  pad_hi_a: assert property (
    rd_ack && paddr_i == `PAD_EN_OFS |-> prdata_o[31:16] == '0)
    else $error("Pad enable upper half not zero");
  all_full_a: assert property (
    st_rd |-> prdata_o[15] == &prdata_o[11:8])
    else $error("All-full flag disagrees with slot flags");
  all_empty_a: assert property (
    st_rd |-> prdata_o[7] == &prdata_o[3:0])
    else $error("All-empty flag disagrees with slot flags");
  oe_follow_a: assert property (
    ext_data_oe_o |-> $past(ext_i.cs && ext_i.rd, 3))
    else $error("Data drive without a read strobe");
  out_hold_a: assert property (
    $changed(ext_data_o) |-> $past(ext_i.rd, 3))
    else $error("Answer byte changed without read strobe");
  pad_en_a: assert property (
    $changed(pad_oe_o) |-> $past(wr_ack) || $past(wr_ack, 2))
    else $error("Pad ownership changed without a write");
  pad_mid_a: assert property (
    $changed(pad_out_o[13:2]) |-> $past(wr_ack) || $past(wr_ack, 2))
    else $error("Address pads changed without a write");
  irq_cause_a: assert property ($rose(port_error_interrupt_o) |->
    $past(wr_ack) || $past(wr_ack, 2) ||
    $past(ext_i.wr || ext_i.rd, 4) || $past(ext_i.wr || ext_i.rd, 5))
    else $error("Interrupt rose without a cause");

  cover property (st_rd && prdata_o[14]);
  cover property (st_rd && prdata_o[6]);
  cover property ($rose(port_error_interrupt_o));
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`include "pport_map.svh"
module tb_top;
  import pport_pkg::*;
  logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, e;
  logic latch_high_i, latch_low_i, pready_o, pslverr_o;
  logic ext_data_oe_o, port_error_interrupt_o;
  logic [7:0] paddr_i, ext_data_o, b;
  logic [31:0] pwdata_i, prdata_o, q;
  logic [15:0] pad_out_o, pad_oe_o;
  ext_bus_t mst, ext_w;
  int miscompares, cmp_count, cyc;

  // Shared data pins: the slave wins while it drives them
  assign ext_w = {mst.cs, mst.wr, mst.rd,
    ext_data_oe_o ? ext_data_o : mst.data};

  pport_slave u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ext_i(ext_w), .ext_data_o(ext_data_o),
    .ext_data_oe_o(ext_data_oe_o), .latch_high_i(latch_high_i),
    .latch_low_i(latch_low_i), .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o), .port_error_interrupt_o(port_error_interrupt_o));
  ext_master_model u_mst (.clk_i(clk_i), .data_i(ext_w.data), .bus_o(mst));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // Idle cycle so a following call never reassigns psel in this step
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, '0);
    chk(q, x);
  endtask
  task automatic irq(input logic x);
    repeat (2) @(posedge clk_i);
    chk({31'h0, port_error_interrupt_o}, {31'h0, x});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pads();
    logic [31:0] en[3] = '{32'hffff_ffff, 32'h0000_c003, 32'h0};
    rd(`PAD_EN_OFS, 32'h0);
    apb(1'b1, `ADDR_OFS, 32'h0000_5a59);
    foreach (en[i]) begin
      apb(1'b1, `PAD_EN_OFS, en[i]);
      rd(`PAD_EN_OFS, {16'h0, en[i][15:0]});
      chk({16'h0, pad_oe_o}, {16'h0, en[i][15:0]});
    end
    apb(1'b1, `PAD_EN_OFS, 32'h0000_ffff);
    for (int k = 0; k < 4; k++) begin
      b = 8'(k);
      apb(1'b1, `CTRL_OFS, {19'h0, 1'b0, b[0], 3'h0, b[1:0], 6'h0});
      repeat (3) @(posedge clk_i);
      chk({16'h0, pad_out_o}, b[0] ? 32'h5a5a : 32'h5a59);
    end
  endtask
  task automatic t_in();
    apb(1'b1, `CTRL_OFS, 32'h1);
    for (int i = 0; i < 4; i++) u_mst.strobe(1'b1, 8'(8'h10 + i), b);
    rd(`STATUS_OFS, 32'h0000_8f8f);
    u_mst.strobe(1'b1, 8'hee, b);
    rd(`STATUS_OFS, 32'h0000_cf8f);
    irq(1'b1);
    rd(`IRQ_STAT_OFS, 32'h1);
    irq(1'b0);
    for (int i = 0; i < 4; i++) begin
      rd(8'(`IN_SLOT_OFS + 4*i), 32'(8'h10 + i));
    end
    rd(`STATUS_OFS, 32'h0000_408f);
    apb(1'b1, `STATUS_OFS, 32'h0);
    rd(`STATUS_OFS, 32'h0000_008f);
  endtask
  task automatic t_out();
    apb(1'b1, `IRQ_MASK_OFS, 32'h3);
    u_mst.strobe(1'b0, 8'h00, b);
    chk({24'h0, b}, 32'h0);
    rd(`STATUS_OFS, 32'h0000_00cf);
    irq(1'b0);
    apb(1'b1, `IRQ_MASK_OFS, 32'h0);
    irq(1'b1);
    rd(`IRQ_STAT_OFS, 32'h2);
    irq(1'b0);
    apb(1'b1, `STATUS_OFS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'(`OUT_SLOT_OFS + 4*i), 32'(8'h80 + i));
    end
    rd(`STATUS_OFS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      u_mst.strobe(1'b0, 8'h00, b);
      chk({24'h0, b}, 32'(8'h80 + i));
    end
    rd(`STATUS_OFS, 32'h0000_008f);
    rd(8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    latch_high_i = 1'b1;
    latch_low_i = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(`STATUS_OFS, 32'h0000_008f);
    t_pads();
    t_in();
    t_out();
    wrap_up();
  end
endmodule

bind pport_slave pport_slave_props #(.SLOTS(SLOTS), .PADS(PADS)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .ext_i(ext_i), .ext_data_o(ext_data_o),
  .ext_data_oe_o(ext_data_oe_o), .latch_high_i(latch_high_i),
  .latch_low_i(latch_low_i), .pad_out_o(pad_out_o),
  .pad_oe_o(pad_oe_o), .port_error_interrupt_o(port_error_interrupt_o));
